// ---- inc/alarm_silence_pkg.sv ----
// Function
// RL1 - Fire LEDs light steadily, not flashing, while alarm-device outputs are disabled.
// RL2 - Each silence button press flips the inside switch between disabled and not disabled.
// RL3 - A disabled inside switch blocks every alarm-device output, an enabled one lets them activate.
// RL4 - Closing the door with the inside switch disabled sounds the buzzer steadily and shows the left-active message.
// RL5 - The left-active message ranks below fire alarms and above every other disablement or fault.
// RL6 - While the outside key switch is on, the inside switch's toggling and gating are ignored.
// RL7 - The outside key switch is a programmable silence-alarms input, turning on means idle to active.
// RL8 - Turning the outside key switch on disables all alarm-device outputs and silences the buzzer.
// RL9 - Turning the outside key switch on raises a switch-active fault that is always latched.
// RL10 - Turning the outside key switch off services that fault, which stays pending until acknowledged.
// RL11 - Turning the outside key switch off isolates every active or acknowledged alarm until re-enabled.
// RL12 - An isolated alarm shows the isolated label instead of the alarm or acknowledged label.
// RL13 - An isolated alarm keeps fire LEDs, buzzer, programmable outputs and fire routing inactive.
// RL14 - The general-disablements LED lights while the outside switch disables outputs or alarms are isolated.
// RL15 - The outside switch is synchronised and each edge applies its actions exactly once.
// RL16 - After reset the inside switch is not disabled, no alarm is isolated and the switch-active fault is clear.
package alarm_silence_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h04;
  localparam logic [7:0] ADDR_PANEL_STATE  = 8'h08;
  localparam logic [7:0] ADDR_FAULT_ACK    = 8'h0C;
  localparam logic [7:0] ADDR_ALARM_STATE  = 8'h10;
  localparam logic [7:0] ADDR_ALARM_ENABLE = 8'h14;

  // interrupt event bits
  localparam int IRQ_BITS         = 4;
  localparam int EV_OUTSIDE_ON    = 0;
  localparam int EV_OUTSIDE_OFF   = 1;
  localparam int EV_LEFT_ACTIVE   = 2;
  localparam int EV_NEW_ALARM     = 3;

  // panel state bits
  localparam int ST_INSIDE_DIS    = 0;
  localparam int ST_OUTSIDE_ON    = 1;
  localparam int ST_FAULT_PEND    = 2;
  localparam int ST_FAULT_SERV    = 3;
  localparam int ST_LEFT_ACTIVE   = 4;
  localparam int ST_GEN_DISABLE   = 5;
  localparam int ST_DISP_LSB      = 8;

  localparam int FAULT_ACK_BIT    = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

  // fire LED flash timing
  localparam int CLK_PERIOD_NS    = 40;
  localparam int FLASH_HALF_MS    = 500;
  localparam int FLASH_CYCLES     = (FLASH_HALF_MS * 1000000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ALM_IDLE, ALM_ACTIVE, ALM_ACKED, ALM_ISOLATED} alarm_state_type;
  typedef enum logic [1:0] {DISP_NONE, DISP_OTHER, DISP_LEFT_ACTIVE, DISP_FIRE} disp_type;

  typedef struct packed {
    logic fireLed;
    logic buzzer;
    logic routing;
    logic genDisableLed;
  } panel_out_type;

endpackage

// ---- rtl/sync_edge.sv ----
module sync_edge
  import alarm_silence_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // raw asynchronous levels
  input  wire logic [WIDTH-1:0] raw,
  // synchronised level and edges
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // meta_q only feeds sync_q
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q; // see RL15
  assign fall  = ~sync_q & prev_q; // see RL15

endmodule

// ---- rtl/alarm_point_table.sv ----
module alarm_point_table
  import alarm_silence_pkg::*;
#(
  parameter int POINTS = 8
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // per-point events and the all-point isolate
  input  wire logic [POINTS-1:0]     raise,
  input  wire logic [POINTS-1:0]     ack,
  input  wire logic [POINTS-1:0]     reenable,
  input  wire logic                  isolateAll,
  // state summary
  output logic      [2*POINTS-1:0]   stateVec,
  output logic                       anyActive,
  output logic                       anyLive,
  output logic                       anyIsolated
);

  alarm_state_type pointState_q [POINTS];

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < POINTS; i++) begin
        pointState_q[i] <= ALM_IDLE; // see RL16
      end
    end else begin
      for (int i = 0; i < POINTS; i++) begin
        case (pointState_q[i])
          ALM_IDLE: begin
            if (raise[i]) begin
              pointState_q[i] <= ALM_ACTIVE;
            end
          end
          ALM_ACTIVE: begin
            if (isolateAll) begin
              pointState_q[i] <= ALM_ISOLATED; // see RL11
            end else if (ack[i]) begin
              pointState_q[i] <= ALM_ACKED;
            end
          end
          ALM_ACKED: begin
            if (isolateAll) begin
              pointState_q[i] <= ALM_ISOLATED; // see RL11
            end
          end
          ALM_ISOLATED: begin
            // only an explicit re-enable leaves isolation
            if (reenable[i]) begin
              pointState_q[i] <= ALM_IDLE; // see RL11
            end
          end
          default: pointState_q[i] <= ALM_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    anyActive   = 1'b0;
    anyLive     = 1'b0;
    anyIsolated = 1'b0;
    stateVec    = '0;
    for (int i = 0; i < POINTS; i++) begin
      stateVec[2*i +: 2] = pointState_q[i]; // see RL12
      anyActive   = anyActive | (pointState_q[i] == ALM_ACTIVE);
      anyLive     = anyLive | (pointState_q[i] == ALM_ACTIVE) | (pointState_q[i] == ALM_ACKED);
      anyIsolated = anyIsolated | (pointState_q[i] == ALM_ISOLATED);
    end
  end

endmodule

// ---- rtl/alarm_silence_ctrl.sv ----
// Added by the designer: register access over AXI4-Lite and the register addresses.
module alarm_silence_ctrl
  import alarm_silence_pkg::*;
#(
  parameter int POINTS       = 8,
  parameter int DEVICES      = 4,
  parameter int FLASH_COUNT  = FLASH_CYCLES
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // front panel pins
  input  wire logic                 silence_button,
  input  wire logic                 outside_key_switch,
  input  wire logic                 doorOpen,
  // detection logic, same clock
  input  wire logic [POINTS-1:0]    alarmRaise,
  input  wire logic [POINTS-1:0]    alarmAck,
  input  wire logic                 otherIndication,
  input  wire logic [DEVICES-1:0]   alarmDeviceReq,
  // indicator outputs
  output logic      [DEVICES-1:0]   alarmDeviceOut,
  output panel_out_type             panelOut,
  output disp_type                  displayCode,
  output logic                      irq,
  // axi4-lite slave
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic      [1:0]           s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp
);

  logic [2:0]          pinLevel;
  logic [2:0]          pinRise;
  logic [2:0]          pinFall;
  logic                buttonPress;
  logic                outsideOn;
  logic                outsideRise;
  logic                outsideFall;
  logic                doorClose;
  logic                insideDisabled_q;
  logic                faultPend_q;
  logic                faultServ_q;
  logic                leftActive_q;
  logic [IRQ_BITS-1:0] irqStatus_q;
  logic [IRQ_BITS-1:0] irqMask_q;
  logic [IRQ_BITS-1:0] irqEvent;
  logic [31:0]         flashCnt_q;
  logic                flashPhase_q;
  logic [2*POINTS-1:0] alarmStates;
  logic                anyActive;
  logic                anyLive;
  logic                anyIsolated;
  logic                anyActive_q;
  logic                devicesDisabled;
  logic                genDisable;
  logic [POINTS-1:0]   reenable;
  logic                faultAck;
  logic                irqClear;
  logic [IRQ_BITS-1:0] irqClearBits;
  disp_type            dispNext;

  // axi write side and read data
  logic                awHeld_q;
  logic [7:0]          awAddr_q;
  logic                wHeld_q;
  logic [31:0]         wData_q;
  logic [3:0]          wStrb_q;
  logic                wrFire;
  logic                wrLane0;
  logic [31:0]         rdData;
  logic                rdHit;

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == ADDR_IRQ_STATUS) || (addr == ADDR_IRQ_MASK) ||
               (addr == ADDR_PANEL_STATE) || (addr == ADDR_FAULT_ACK) ||
               (addr == ADDR_ALARM_STATE) || (addr == ADDR_ALARM_ENABLE);
  endfunction

  sync_edge #(
    .WIDTH (3)
  ) u_pins (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .raw     ({doorOpen, outside_key_switch, silence_button}),
    .level   (pinLevel),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  assign buttonPress = pinRise[0];
  assign outsideOn   = pinLevel[1]; // see RL7
  assign outsideRise = pinRise[1];  // see RL7
  assign outsideFall = pinFall[1];
  assign doorClose   = pinFall[2];

  alarm_point_table #(
    .POINTS (POINTS)
  ) u_points (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .raise       (alarmRaise),
    .ack         (alarmAck),
    .reenable    (reenable),
    .isolateAll  (outsideFall), // see RL11
    .stateVec    (alarmStates),
    .anyActive   (anyActive),
    .anyLive     (anyLive),
    .anyIsolated (anyIsolated)
  );

  // toggles only while the key is off
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      insideDisabled_q <= 1'b0; // see RL16
    end else if (buttonPress && !outsideOn) begin
      insideDisabled_q <= ~insideDisabled_q; // see RL2, see RL6
    end
  end

  // key overrides the inside gating
  assign devicesDisabled = outsideOn | insideDisabled_q; // see RL3, see RL6, see RL8
  assign genDisable      = outsideOn | anyIsolated;      // see RL14

  // switch-active fault: always latched, set beats acknowledge
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      faultPend_q <= 1'b0; // see RL16
      faultServ_q <= 1'b0;
    end else if (outsideRise) begin
      faultPend_q <= 1'b1; // see RL9
      faultServ_q <= 1'b0;
    end else begin
      if (outsideFall && faultPend_q) begin
        faultServ_q <= 1'b1; // see RL10
      end
      // acknowledge only takes once the fault is serviced
      if (faultAck && faultServ_q) begin
        faultPend_q <= 1'b0; // see RL10
        faultServ_q <= 1'b0;
      end
    end
  end

  // left-active, cleared on door open, re-enable or key on
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      leftActive_q <= 1'b0;
    end else if (doorClose && insideDisabled_q && !outsideOn) begin
      leftActive_q <= 1'b1; // see RL4
    end else if (pinLevel[2] || !insideDisabled_q || outsideOn) begin
      leftActive_q <= 1'b0;
    end
  end

  // flash divider for the fire LEDs
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flashCnt_q   <= '0;
      flashPhase_q <= 1'b0;
    end else if (flashCnt_q >= 32'(FLASH_COUNT - 1)) begin
      flashCnt_q   <= '0;
      flashPhase_q <= ~flashPhase_q;
    end else begin
      flashCnt_q <= flashCnt_q + 32'h0000_0001;
    end
  end

  // display ranking
  always_comb begin
    if (anyLive) begin
      dispNext = DISP_FIRE;
    end else if (leftActive_q) begin
      dispNext = DISP_LEFT_ACTIVE; // see RL5
    end else if (otherIndication || genDisable || faultPend_q) begin
      dispNext = DISP_OTHER;
    end else begin
      dispNext = DISP_NONE;
    end
  end

  // registered panel outputs; isolated points count as no alarm
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      panelOut       <= '0;
      alarmDeviceOut <= '0;
      displayCode    <= DISP_NONE;
    end else begin
      // steady while disabled, else flashing
      panelOut.fireLed <= anyLive & (devicesDisabled | flashPhase_q); // see RL1, see RL13
      // key silences buzzer, left-active sounds it
      panelOut.buzzer  <= !outsideOn & (anyActive | leftActive_q); // see RL4, see RL8, see RL13
      panelOut.routing <= anyLive;                                 // see RL13
      panelOut.genDisableLed <= genDisable;                        // see RL14
      alarmDeviceOut <= anyLive && !devicesDisabled ? alarmDeviceReq : '0; // see RL3, see RL13
      displayCode    <= dispNext;
    end
  end

  // interrupt events, sticky until written with one
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      anyActive_q <= 1'b0;
    end else begin
      anyActive_q <= anyActive;
    end
  end

  always_comb begin
    irqEvent                 = '0;
    irqEvent[EV_OUTSIDE_ON]  = outsideRise;
    irqEvent[EV_OUTSIDE_OFF] = outsideFall;
    irqEvent[EV_LEFT_ACTIVE] = doorClose && insideDisabled_q && !outsideOn;
    irqEvent[EV_NEW_ALARM]   = anyActive && !anyActive_q;
  end

  assign irqClearBits = irqClear ? wData_q[IRQ_BITS-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irqStatus_q <= '0;
      irq         <= 1'b0;
    end else begin
      // new events win over a clear in the same cycle
      irqStatus_q <= (irqStatus_q & ~irqClearBits) | irqEvent;
      irq         <= |(irqStatus_q & irqMask_q);
    end
  end

  // write channel: address and data taken in either order
  assign wrFire  = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrLane0 = wrFire && wStrb_q[0];
  assign irqClear = wrLane0 && (awAddr_q == ADDR_IRQ_STATUS);
  assign faultAck = wrLane0 && (awAddr_q == ADDR_FAULT_ACK) && wData_q[FAULT_ACK_BIT];
  assign reenable = (wrFire && awAddr_q == ADDR_ALARM_ENABLE) ? wData_q[POINTS-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      awHeld_q      <= 1'b0;
      awAddr_q      <= '0;
      wHeld_q       <= 1'b0;
      wData_q       <= '0;
      wStrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeld_q      <= 1'b0;
        wHeld_q       <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irqMask_q <= '0;
    end else if (wrLane0 && awAddr_q == ADDR_IRQ_MASK) begin
      irqMask_q <= wData_q[IRQ_BITS-1:0];
    end
  end

  // read channel
  always_comb begin
    rdData = DATA_ZERO;
    rdHit  = isMapped(s_axi_araddr);
    case (s_axi_araddr)
      ADDR_IRQ_STATUS:  rdData[IRQ_BITS-1:0] = irqStatus_q;
      ADDR_IRQ_MASK:    rdData[IRQ_BITS-1:0] = irqMask_q;
      ADDR_PANEL_STATE: begin
        rdData[ST_INSIDE_DIS]  = insideDisabled_q;
        rdData[ST_OUTSIDE_ON]  = outsideOn;
        rdData[ST_FAULT_PEND]  = faultPend_q;
        rdData[ST_FAULT_SERV]  = faultServ_q;
        rdData[ST_LEFT_ACTIVE] = leftActive_q;
        rdData[ST_GEN_DISABLE] = genDisable;
        rdData[ST_DISP_LSB +: 2] = displayCode;
      end
      ADDR_ALARM_STATE: rdData[2*POINTS-1:0] = alarmStates; // see RL12
      default:          rdData = DATA_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= DATA_ZERO;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdData;
        s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- verification/alarm_silence_monitor.sv ----
module alarm_silence_monitor
  import alarm_silence_pkg::*;
#(
  parameter int DEVICES = 4
) (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               reset_n,
  // panel side
  input wire logic               outside_key_switch,
  input wire logic [DEVICES-1:0] alarmDeviceReq,
  input wire logic [DEVICES-1:0] alarmDeviceOut,
  input wire panel_out_type      panelOut,
  input wire disp_type           displayCode,
  // bus answers
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // key held cycles; outputs settle within four
  logic [3:0] onCnt;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !outside_key_switch) begin
      onCnt <= 4'h0;
    end else if (onCnt != 4'hF) begin
      onCnt <= onCnt + 4'h1;
    end
  end

  a_reset_clear: assert property ($rose(reset_n) |-> panelOut == '0 && displayCode == DISP_NONE)
    else $error("outputs after reset");
  a_dev_req: assert property ((alarmDeviceOut & ~$past(alarmDeviceReq)) == '0)
    else $error("output without request");
  a_dev_blocked: assert property (onCnt >= 4'h6 |-> alarmDeviceOut == '0)
    else $error("output while key on");
  a_buzz_silenced: assert property (onCnt >= 4'h6 |-> !panelOut.buzzer)
    else $error("buzzer while key on");
  a_gen_led: assert property (onCnt >= 4'h6 |-> panelOut.genDisableLed)
    else $error("disablement led dark");
  a_fire_steady: assert property ((onCnt >= 4'h6 && panelOut.fireLed) ##1 onCnt >= 4'h6
    |-> panelOut.fireLed)
    else $error("fire led flashing");
  a_fire_rank: assert property (panelOut.routing [*2] |-> displayCode == DISP_FIRE)
    else $error("fire not on top");
  a_left_buzz: assert property ((displayCode == DISP_LEFT_ACTIVE) [*2] |-> panelOut.buzzer)
    else $error("left active without buzzer");
  a_iso_dark: assert property ($fell(outside_key_switch)
    |-> ##[5:8] (!panelOut.routing && !panelOut.fireLed))
    else $error("isolated alarm shown");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  c_left: cover property (displayCode == DISP_LEFT_ACTIVE);
  c_key_held: cover property (onCnt == 4'hF && panelOut.fireLed);
  c_key_off: cover property ($fell(outside_key_switch));
endmodule

// ---- verification/panel_pins.sv ----
module panel_pins (
  // clock
  input wire logic ref_clk,
  // front panel pins
  output logic     silence_button = 1'b0,
  output logic     outside_key_switch = 1'b0,
  output logic     doorOpen = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;

  // held four cycles so the synchroniser cannot miss it
  task automatic press();
    @(posedge ref_clk);
    silence_button <= 1'b1;
    repeat (4) @(posedge ref_clk);
    silence_button <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic set_key(input logic on);
    @(posedge ref_clk);
    outside_key_switch <= on;
  endtask

  task automatic set_door(input logic open);
    @(posedge ref_clk);
    doorOpen <= open;
  endtask
endmodule

// ---- verification/tb_top.sv ----
module tb_top
  import alarm_silence_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          ref_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic          silence_button, outside_key_switch, doorOpen, irq;
  logic          otherIndication = 1'b0;
  logic [1:0]    alarmRaise = 2'h0, alarmAck = 2'h0, alarmDeviceReq = 2'h0, alarmDeviceOut;
  panel_out_type panelOut;
  disp_type      displayCode;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]   s_axi_wdata = 32'h0000_0000, s_axi_rdata, v;
  logic [3:0]    s_axi_wstrb = 4'h0;
  logic [1:0]    s_axi_bresp, s_axi_rresp, r;
  int            bad_count = 0, total_checks = 0, cycles = 0;

  always #20 ref_clk = ~ref_clk;

  // short flash period keeps led checks brief
  alarm_silence_ctrl #(.POINTS(2), .DEVICES(2), .FLASH_COUNT(4)) DUT (
    .ref_clk, .reset_n, .silence_button, .outside_key_switch, .doorOpen, .alarmRaise,
    .alarmAck, .otherIndication, .alarmDeviceReq, .alarmDeviceOut, .panelOut, .displayCode,
    .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  panel_pins pins (.ref_clk, .silence_button, .outside_key_switch, .doorOpen);

  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: %s is %0h, want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    axi_read(a, v, r);
    check(32'(r), 32'(RESP_OKAY), "read resp");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hF, r);
    check(32'(r), 32'(RESP_OKAY), "write resp");
  endtask

  task automatic bit_is(input int b, input logic e, input string what);
    check(32'(v[b]), 32'(e), what);
  endtask

  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask

  // dark led cycles over three flash half-periods
  task automatic dark_cycles(output int low);
    low = 0;
    repeat (12) begin
      @(posedge ref_clk);
      low += int'(!panelOut.fireLed);
    end
  endtask

  task automatic reset_values();
    rd(ADDR_PANEL_STATE);
    check(v, DATA_ZERO, "panel after reset");
    rd(ADDR_ALARM_STATE);
    check(v, DATA_ZERO, "alarms after reset");
    axi_read(8'h20, v, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped read resp");
    check(v, DATA_ZERO, "unmapped read data");
    axi_write(8'h20, 32'hFFFF_FFFF, 4'hF, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped write resp");
    axi_write(ADDR_IRQ_MASK, 32'hF, 4'hE, r);
    rd(ADDR_IRQ_MASK);
    check(v, DATA_ZERO, "mask kept without lane 0");
  endtask

  task automatic left_active();
    pins.press();
    pins.set_door(1'b1);
    settle();
    rd(ADDR_PANEL_STATE);
    bit_is(ST_INSIDE_DIS, 1'b1, "press disables");
    pins.set_door(1'b0);
    settle();
    check(32'(displayCode), 32'(DISP_LEFT_ACTIVE), "left active message");
    check(32'(panelOut.buzzer), 32'h1, "door close buzzer");
    otherIndication <= 1'b1;
    settle();
    check(32'(displayCode), 32'(DISP_LEFT_ACTIVE), "left over other");
    pins.set_door(1'b1);
    settle();
    check(32'(displayCode), 32'(DISP_OTHER), "other after door opens");
  endtask

  task automatic gating();
    int low;
    alarmDeviceReq <= 2'h2;
    alarmRaise <= 2'h1;
    @(posedge ref_clk);
    alarmRaise <= 2'h0;
    settle();
    check(32'(alarmDeviceOut), 32'h0, "outputs blocked");
    check(32'(displayCode), 32'(DISP_FIRE), "fire above other");
    dark_cycles(low);
    check(32'(low), 32'h0, "leds steady");
    pins.press();
    settle();
    check(32'(alarmDeviceOut), 32'h2, "outputs follow req");
    dark_cycles(low);
    check(32'(low != 0), 32'h1, "leds flash");
    alarmRaise <= 2'h2;
    @(posedge ref_clk);
    alarmRaise <= 2'h0;
    alarmAck <= 2'h2;
    @(posedge ref_clk);
    alarmAck <= 2'h0;
    settle();
    rd(ADDR_ALARM_STATE);
    check(v, 32'h9, "active and acked");
  endtask

  task automatic key_on();
    wr(ADDR_IRQ_MASK, 32'h1);
    pins.set_key(1'b1);
    settle();
    rd(ADDR_PANEL_STATE);
    bit_is(ST_OUTSIDE_ON, 1'b1, "key sensed");
    bit_is(ST_FAULT_PEND, 1'b1, "fault raised");
    bit_is(ST_GEN_DISABLE, 1'b1, "gen disable");
    check(32'(alarmDeviceOut), 32'h0, "key blocks outputs");
    check(32'(panelOut.buzzer), 32'h0, "buzzer silenced");
    check(32'(irq), 32'h1, "key on interrupt");
    pins.press();
    settle();
    rd(ADDR_PANEL_STATE);
    bit_is(ST_INSIDE_DIS, 1'b0, "inside ignored");
    wr(ADDR_IRQ_STATUS, 32'hF);
    repeat (2) @(posedge ref_clk);
    check(32'(irq), 32'h0, "irq cleared");
  endtask

  task automatic key_off();
    pins.set_key(1'b0);
    settle();
    rd(ADDR_PANEL_STATE);
    bit_is(ST_FAULT_SERV, 1'b1, "fault serviced");
    bit_is(ST_FAULT_PEND, 1'b1, "fault pending");
    bit_is(ST_GEN_DISABLE, 1'b1, "isolation shown");
    rd(ADDR_ALARM_STATE);
    check(v, 32'hF, "points isolated");
    check(32'(panelOut), 32'h1, "isolated dark");
    check(32'(alarmDeviceOut), 32'h0, "outputs off");
    check(32'(irq), 32'h0, "masked event quiet");
    rd(ADDR_IRQ_STATUS);
    check(v, 32'h2, "off latched once");
    wr(ADDR_FAULT_ACK, 32'h1);
    repeat (10) @(posedge ref_clk);
    rd(ADDR_PANEL_STATE);
    bit_is(ST_FAULT_PEND, 1'b0, "fault acked");
    wr(ADDR_ALARM_ENABLE, 32'h3);
    settle();
    rd(ADDR_ALARM_STATE);
    check(v, DATA_ZERO, "re-enabled");
    check(32'(panelOut.genDisableLed), 32'h0, "no disablement");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    reset_values();
    left_active();
    gating();
    key_on();
    key_off();
    complete_run();
  end
endmodule

bind alarm_silence_ctrl alarm_silence_monitor #(.DEVICES(DEVICES)) mon (
  .ref_clk, .reset_n, .outside_key_switch, .alarmDeviceReq, .alarmDeviceOut, .panelOut,
  .displayCode, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
